// File: hw/ccd_seq_pkg.sv
// constants and types for the ccd clock sequencer
package ccd_seq_pkg;
    // resolution / gain selection
    localparam logic [1:0] GAIN_HIGH = 2'h0;
    localparam logic [1:0] GAIN_LOW = 2'h1;
    localparam logic [1:0] GAIN_EXTENDED_RANGE_MODE = 2'h2;
    // output enable mask bit positions
    localparam int OUT_A = 0;
    localparam int OUT_B = 1;
    localparam int OUT_C = 2;
    localparam int OUT_D = 3;
    // timing defaults, in clock cycles; line length in pixels
    localparam int HALF_PIX_CYC = 4;
    localparam int VHALF_CYC = 8;
    localparam int XFER_CYC = 32;
    localparam int SHUT_CYC = 16;
    localparam int DUMP_GUARD_CYC = 2;
    localparam int PIX_PER_LINE = 16;
    // static pin levels (logic level 1 = pin's high level)
    localparam logic PIN_HIGH = 1'b1;
    localparam logic PIN_LOW = 1'b0;
    typedef enum logic [2:0] {
        ST_IDLE, ST_XFER, ST_VGUARD, ST_VSHIFT, ST_DGUARD, ST_HREAD, ST_SHUT, ST_SWAIT
    } seq_state_e;
endpackage

// File: hw/pix_phase_gen.sv
// pixel phase generator: horizontal clocks and sample strobes
`timescale 1ns/100ps
module pix_phase_gen #(
    parameter int HALF_CYC = ccd_seq_pkg::HALF_PIX_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic quarter,
    output logic h1,
    output logic pix_tick,
    output logic samp_rst,
    output logic samp_dat,
    output logic pair_odd
);
    logic [7:0] cnt_r;
    logic odd_r;
    logic last;
    assign last = (cnt_r == 8'(HALF_CYC - 1));
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 8'h00;
        end else if (!run || last) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            h1 <= 1'b1;
            odd_r <= 1'b0;
        end else if (!run) begin
            h1 <= 1'b1;
            odd_r <= 1'b0;
        end else if (last) begin
            h1 <= ~h1;
            if (!h1) begin
                odd_r <= ~odd_r;
            end
        end
    end
    // one pixel ends when h1 rises again
    assign pix_tick = run && last && !h1;
    assign pair_odd = odd_r;
    // strobes: reset level early in h1 high, data level early in h1 low
    // quarter: only every second pixel, i.e. half rate
    assign samp_rst = run && h1 && (cnt_r == 8'h01) && (!quarter || !odd_r);
    assign samp_dat = run && !h1 && (cnt_r == 8'h01) && (!quarter || odd_r);
endmodule // pix_phase_gen

// File: hw/ccd_readout_clock_sequencer.sv
// camera timing generator driving an interline ccd
`timescale 1ns/100ps
// Function
// [R1] transfer pulse rising starts photodiode transfer, falling completes it
// [R2] anti-blooming off while transfer pulse high; keep pulse bounded
// [R3] exposure ends on transfer pulse falling edge
// [R4] dumped line: pulse both dump gates around its vertical transfer, no horizontal clocking
// [R5] normal line: both dump gates held low through vertical transfer
// [R6] vertical clocks with dump gates high send charge to drain
// [R7] dump gates high before first vertical edge of dumped transfer
// [R8] dump gates stay high until last vertical edge completes
// [R9] shutter pulse only at line end with horizontal register empty
// [R10] shutter placed right after last pixel of a line
// [R11] vertical clocks stopped at least half vertical period after shutter
// [R12] horizontal clocks may run in shutter only with no valid data
// [R13] sub-line shutter edges kept half vertical period from vertical edges
// [R14] full-resolution sample strobes go to front end only
// [R15] permanent high gain: secondary resets held static
// [R16] permanent low gain: all four primary resets held static
// [R17] quarter high gain: primary resets pulsed at half horizontal rate
// [R18] quarter low gain: secondary resets pulsed at half horizontal rate
// [R19] quarter strobes run at half horizontal rate
// [R20] unused outputs' horizontal and reset clocks held high
// [R21] extended range: separate low and high gain strobe pairs
// [R22] extended range: two-pixel horizontal plus two-line vertical summing
// [R23] mode configuration latched only between frames
module ccd_readout_clock_sequencer #(
    parameter int XFER_CYC = ccd_seq_pkg::XFER_CYC,
    parameter int VHALF_CYC = ccd_seq_pkg::VHALF_CYC,
    parameter int SHUT_CYC = ccd_seq_pkg::SHUT_CYC,
    parameter int PIX_PER_LINE = ccd_seq_pkg::PIX_PER_LINE,
    parameter int HALF_PIX_CYC = ccd_seq_pkg::HALF_PIX_CYC,
    parameter int LINES = 8
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic FRAME_START,
    input wire logic [1:0] GAIN_SEL,
    input wire logic QUARTER_SEL,
    input wire logic [3:0] OUT_EN,
    input wire logic [15:0] DUMP_LINES,
    input wire logic [15:0] SHUTTER_LINE,
    input wire logic SHUTTER_EN,
    output logic TOP_TRANSFER_GATE,
    output logic BOTTOM_TRANSFER_GATE,
    output logic VERT_CLK,
    output logic DUMP_GATE_UPPER_PAIR,
    output logic DUMP_GATE_LOWER_PAIR,
    output logic SHUTTER,
    output logic [3:0] HORIZ_CLK1,
    output logic [3:0] PRIMARY_RESET,
    output logic SECONDARY_RESET_UPPER,
    output logic SECONDARY_RESET_LOWER,
    output logic FULL_RES_RESET_SAMPLE,
    output logic FULL_RES_DATA_SAMPLE,
    output logic QUARTER_RES_RESET_SAMPLE,
    output logic QUARTER_RES_DATA_SAMPLE,
    output logic LOW_GAIN_RESET_SAMPLE,
    output logic LOW_GAIN_DATA_SAMPLE,
    output logic HIGH_GAIN_RESET_SAMPLE,
    output logic HIGH_GAIN_DATA_SAMPLE,
    output logic BUSY
);
    // ------------------------------------------------------------
    // configuration latch
    // ------------------------------------------------------------
    ccd_seq_pkg::seq_state_e state_r, state_nxt;
    logic [1:0] gain_r;
    logic quarter_r;
    logic [3:0] outen_r;
    logic [15:0] cnt_r;
    logic [15:0] line_r;
    logic [7:0] pix_r;
    logic vphase_r;
    logic dump_line;
    logic h1, pix_tick, samp_rst, samp_dat, pair_odd;
    logic hrun;
    logic vsum_r;

    function automatic logic is_extended_range_mode(input logic [1:0] g);
        is_extended_range_mode = (g == ccd_seq_pkg::GAIN_EXTENDED_RANGE_MODE);
    endfunction

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            gain_r <= ccd_seq_pkg::GAIN_HIGH;
            quarter_r <= 1'b0;
            outen_r <= 4'h1;
        end else if (state_r == ccd_seq_pkg::ST_IDLE && FRAME_START) begin
            // mid-frame changes would corrupt line sums
            gain_r <= GAIN_SEL; // [R23]
            quarter_r <= QUARTER_SEL | is_extended_range_mode(GAIN_SEL); // [R22]
            outen_r <= OUT_EN;
        end
    end

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    assign dump_line = (line_r < 16'd16) ? DUMP_LINES[line_r[3:0]] : 1'b0;
    assign hrun = (state_r == ccd_seq_pkg::ST_HREAD);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ccd_seq_pkg::ST_IDLE:
                if (FRAME_START) begin
                    state_nxt = ccd_seq_pkg::ST_XFER;
                end
            ccd_seq_pkg::ST_XFER:
                if (cnt_r == 16'(XFER_CYC - 1)) begin
                    state_nxt = ccd_seq_pkg::ST_VGUARD;
                end
            ccd_seq_pkg::ST_VGUARD:
                if (cnt_r == 16'(VHALF_CYC - 1)) begin
                    state_nxt = ccd_seq_pkg::ST_VSHIFT;
                end
            ccd_seq_pkg::ST_VSHIFT:
                if (cnt_r == 16'(4 * VHALF_CYC - 1)) begin
                    state_nxt = ccd_seq_pkg::ST_DGUARD;
                end
            ccd_seq_pkg::ST_DGUARD:
                if (cnt_r == 16'(ccd_seq_pkg::DUMP_GUARD_CYC - 1)) begin
                    // dumped line skips horizontal readout
                    state_nxt = dump_line ? ccd_seq_pkg::ST_SWAIT : ccd_seq_pkg::ST_HREAD; // [R4]
                end
            ccd_seq_pkg::ST_HREAD:
                if (pix_tick && pix_r == 8'(PIX_PER_LINE - 1)) begin
                    // shutter right after the last pixel, register empty
                    state_nxt = (SHUTTER_EN && line_r == SHUTTER_LINE) ?
                        ccd_seq_pkg::ST_SHUT : ccd_seq_pkg::ST_SWAIT; // [R9] [R10]
                end
            ccd_seq_pkg::ST_SHUT:
                if (cnt_r == 16'(SHUT_CYC - 1)) begin
                    state_nxt = ccd_seq_pkg::ST_SWAIT;
                end
            ccd_seq_pkg::ST_SWAIT:
                // half vertical period of quiet before vertical clocks resume
                if (cnt_r == 16'(VHALF_CYC - 1)) begin
                    state_nxt = (line_r == 16'(LINES - 1)) ?
                        ccd_seq_pkg::ST_IDLE : ccd_seq_pkg::ST_VGUARD; // [R11] [R13]
                end
            default:
                state_nxt = ccd_seq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= ccd_seq_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt_r <= 16'h0000;
        end else if (state_nxt != state_r) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            line_r <= 16'h0000;
            pix_r <= 8'h00;
        end else begin
            if (state_r == ccd_seq_pkg::ST_IDLE) begin
                line_r <= 16'h0000;
            end else if (state_r == ccd_seq_pkg::ST_SWAIT && state_nxt != state_r) begin
                line_r <= line_r + 16'h0001;
            end
            if (!hrun) begin
                pix_r <= 8'h00;
            end else if (pix_tick) begin
                pix_r <= pix_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // vertical, transfer and dump gate pins
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            TOP_TRANSFER_GATE <= 1'b0;
            BOTTOM_TRANSFER_GATE <= 1'b0;
        end else begin
            // pulse width bounded: anti-blooming is off while high, exposure ends on fall
            TOP_TRANSFER_GATE <= (state_nxt == ccd_seq_pkg::ST_XFER); // [R1] [R2] [R3]
            BOTTOM_TRANSFER_GATE <= (state_nxt == ccd_seq_pkg::ST_XFER); // [R1]
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            VERT_CLK <= 1'b0;
            vphase_r <= 1'b0;
            vsum_r <= 1'b0;
        end else if (state_r == ccd_seq_pkg::ST_VSHIFT) begin
            // two full vertical periods per line: extended_range_mode sums two lines, others shift one
            if (cnt_r[7:0] == 8'(VHALF_CYC - 1) || cnt_r[7:0] == 8'(3 * VHALF_CYC - 1)
                || (is_extended_range_mode(gain_r) && cnt_r[7:0] == 8'(2 * VHALF_CYC - 1))) begin
                vphase_r <= ~vphase_r;
            end
            VERT_CLK <= vphase_r; // [R22]
            vsum_r <= is_extended_range_mode(gain_r);
        end else begin
            VERT_CLK <= 1'b0;
            vphase_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            DUMP_GATE_UPPER_PAIR <= 1'b0;
            DUMP_GATE_LOWER_PAIR <= 1'b0;
        end else begin
            // from present state: line index is only valid once the guard is entered
            DUMP_GATE_UPPER_PAIR <= dump_line && (state_r == ccd_seq_pkg::ST_VGUARD
                || state_r == ccd_seq_pkg::ST_VSHIFT || state_r == ccd_seq_pkg::ST_DGUARD); // [R4] [R5] [R6] [R7] [R8]
            DUMP_GATE_LOWER_PAIR <= dump_line && (state_r == ccd_seq_pkg::ST_VGUARD
                || state_r == ccd_seq_pkg::ST_VSHIFT || state_r == ccd_seq_pkg::ST_DGUARD); // [R4] [R5]
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SHUTTER <= 1'b0;
            BUSY <= 1'b0;
        end else begin
            SHUTTER <= (state_nxt == ccd_seq_pkg::ST_SHUT); // [R9]
            BUSY <= (state_nxt != ccd_seq_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // pixel timing
    // ------------------------------------------------------------
    pix_phase_gen #(
        .HALF_CYC(HALF_PIX_CYC)
    ) u_pix (
        .clk(CLK),
        .rst_b(RST_B),
        .run(hrun),
        .quarter(quarter_r),
        .h1(h1),
        .pix_tick(pix_tick),
        .samp_rst(samp_rst),
        .samp_dat(samp_dat),
        .pair_odd(pair_odd)
    );

    // horizontal clocks idle high outside readout, so none run in the shutter
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_out
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    HORIZ_CLK1[gi] <= ccd_seq_pkg::PIN_HIGH;
                    PRIMARY_RESET[gi] <= ccd_seq_pkg::PIN_HIGH;
                end else if (!outen_r[gi]) begin
                    HORIZ_CLK1[gi] <= ccd_seq_pkg::PIN_HIGH; // [R20]
                    PRIMARY_RESET[gi] <= ccd_seq_pkg::PIN_HIGH; // [R20]
                end else begin
                    HORIZ_CLK1[gi] <= hrun ? h1 : ccd_seq_pkg::PIN_HIGH; // [R12]
                    if (gain_r == ccd_seq_pkg::GAIN_LOW) begin
                        PRIMARY_RESET[gi] <= ccd_seq_pkg::PIN_HIGH; // [R16]
                    end else begin
                        // quarter: reset only once per pixel pair
                        // idle high, so a mask change at frame start shows no low level
                        PRIMARY_RESET[gi] <= !hrun || samp_rst_pulse(hrun, h1, quarter_r, pair_odd); // [R17]
                    end
                end
            end
        end
    endgenerate

    function automatic logic samp_rst_pulse(input logic run, input logic ph, input logic q, input logic odd);
        samp_rst_pulse = run && ph && (!q || !odd);
    endfunction

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SECONDARY_RESET_UPPER <= ccd_seq_pkg::PIN_HIGH;
            SECONDARY_RESET_LOWER <= ccd_seq_pkg::PIN_HIGH;
        end else if (gain_r == ccd_seq_pkg::GAIN_HIGH) begin
            SECONDARY_RESET_UPPER <= ccd_seq_pkg::PIN_HIGH; // [R15]
            SECONDARY_RESET_LOWER <= ccd_seq_pkg::PIN_HIGH; // [R15]
        end else begin
            SECONDARY_RESET_UPPER <= !hrun || samp_rst_pulse(hrun, h1, quarter_r, pair_odd)
                || !(outen_r[ccd_seq_pkg::OUT_A] || outen_r[ccd_seq_pkg::OUT_B]); // [R18]
            SECONDARY_RESET_LOWER <= !hrun || samp_rst_pulse(hrun, h1, quarter_r, pair_odd)
                || !(outen_r[ccd_seq_pkg::OUT_C] || outen_r[ccd_seq_pkg::OUT_D]); // [R18] [R20]
        end
    end

    // ------------------------------------------------------------
    // front-end sample strobes (never routed to sensor pins)
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            FULL_RES_RESET_SAMPLE <= 1'b0;
            FULL_RES_DATA_SAMPLE <= 1'b0;
            QUARTER_RES_RESET_SAMPLE <= 1'b0;
            QUARTER_RES_DATA_SAMPLE <= 1'b0;
            LOW_GAIN_RESET_SAMPLE <= 1'b0;
            LOW_GAIN_DATA_SAMPLE <= 1'b0;
            HIGH_GAIN_RESET_SAMPLE <= 1'b0;
            HIGH_GAIN_DATA_SAMPLE <= 1'b0;
        end else begin
            FULL_RES_RESET_SAMPLE <= samp_rst && !quarter_r; // [R14]
            FULL_RES_DATA_SAMPLE <= samp_dat && !quarter_r; // [R14]
            QUARTER_RES_RESET_SAMPLE <= samp_rst && quarter_r && !is_extended_range_mode(gain_r); // [R19]
            QUARTER_RES_DATA_SAMPLE <= samp_dat && quarter_r && !is_extended_range_mode(gain_r); // [R19]
            // both gain pairs sample the same summed pixel
            LOW_GAIN_RESET_SAMPLE <= samp_rst && is_extended_range_mode(gain_r) && vsum_r; // [R21]
            LOW_GAIN_DATA_SAMPLE <= samp_dat && is_extended_range_mode(gain_r) && vsum_r; // [R21]
            HIGH_GAIN_RESET_SAMPLE <= samp_rst && is_extended_range_mode(gain_r) && vsum_r; // [R21]
            HIGH_GAIN_DATA_SAMPLE <= samp_dat && is_extended_range_mode(gain_r) && vsum_r; // [R21]
        end
    end
endmodule // ccd_readout_clock_sequencer

// File: verif/ccd_seq_checker_assertions.sv
// concurrent checks on the ccd clock sequencer ports
`timescale 1ns/100ps
module ccd_seq_checker #(
    parameter int XFER_CYC = ccd_seq_pkg::XFER_CYC,
    parameter int HALF_PIX_CYC = ccd_seq_pkg::HALF_PIX_CYC
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic FRAME_START,
    input wire logic [1:0] GAIN_SEL,
    input wire logic [3:0] OUT_EN,
    input wire logic TOP_TRANSFER_GATE,
    input wire logic BOTTOM_TRANSFER_GATE,
    input wire logic VERT_CLK,
    input wire logic DUMP_GATE_UPPER_PAIR,
    input wire logic DUMP_GATE_LOWER_PAIR,
    input wire logic SHUTTER,
    input wire logic [3:0] HORIZ_CLK1,
    input wire logic [3:0] PRIMARY_RESET,
    input wire logic SECONDARY_RESET_UPPER,
    input wire logic SECONDARY_RESET_LOWER,
    input wire logic QUARTER_RES_RESET_SAMPLE,
    input wire logic LOW_GAIN_RESET_SAMPLE,
    input wire logic LOW_GAIN_DATA_SAMPLE,
    input wire logic HIGH_GAIN_RESET_SAMPLE,
    input wire logic HIGH_GAIN_DATA_SAMPLE,
    input wire logic BUSY
);
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    logic [1:0] gain_r;
    logic [3:0] oen_r;
    int gate_cnt_r;
    int qgap_r;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // config copy, taken at the same edge as the design's
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            gain_r <= ccd_seq_pkg::GAIN_HIGH;
            oen_r <= 4'h1;
        end else if (FRAME_START && !BUSY) begin
            gain_r <= GAIN_SEL;
            oen_r <= OUT_EN;
        end
    end
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            gate_cnt_r <= 0;
        end else begin
            gate_cnt_r <= TOP_TRANSFER_GATE ? gate_cnt_r + 1 : 0;
        end
    end
    // saturates so the first strobe after reset passes
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            qgap_r <= 1000;
        end else begin
            qgap_r <= QUARTER_RES_RESET_SAMPLE ? 0 : (qgap_r < 1000 ? qgap_r + 1 : qgap_r);
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    start_answer_a: assert property (FRAME_START && !BUSY |=> BUSY && TOP_TRANSFER_GATE)
        else $error("frame start not answered");
    gates_paired_a: assert property (TOP_TRANSFER_GATE == BOTTOM_TRANSFER_GATE)
        else $error("transfer gates differ");
    pulse_width_a: assert property ($fell(TOP_TRANSFER_GATE) |-> gate_cnt_r == XFER_CYC)
        else $error("transfer pulse width off");
    dump_paired_a: assert property (DUMP_GATE_UPPER_PAIR == DUMP_GATE_LOWER_PAIR)
        else $error("dump gates differ");
    dump_lead_a: assert property ($changed(VERT_CLK) && DUMP_GATE_UPPER_PAIR |-> $past(DUMP_GATE_UPPER_PAIR))
        else $error("dump gate late for vertical edge");
    dump_trail_a: assert property ($fell(DUMP_GATE_UPPER_PAIR) |-> $stable(VERT_CLK) && $past(VERT_CLK, 2) == $past(VERT_CLK))
        else $error("dump gate fell too soon");
    dump_no_horiz_a: assert property (DUMP_GATE_UPPER_PAIR |-> HORIZ_CLK1 == 4'hF)
        else $error("horizontal clocked during dump");
    shut_quiet_a: assert property ($fell(SHUTTER) |-> $stable(VERT_CLK) [*8])
        else $error("vertical resumed too soon");
    shut_still_a: assert property (SHUTTER |-> $stable(VERT_CLK))
        else $error("vertical edge inside shutter");
    unused_high_a: assert property ((HORIZ_CLK1 | oen_r) == 4'hF && (PRIMARY_RESET | oen_r) == 4'hF)
        else $error("unused output clock moved");
    low_static_a: assert property (gain_r == ccd_seq_pkg::GAIN_LOW |-> PRIMARY_RESET == 4'hF)
        else $error("primary reset pulsed in low gain");
    high_static_a: assert property (gain_r == ccd_seq_pkg::GAIN_HIGH |-> SECONDARY_RESET_UPPER && SECONDARY_RESET_LOWER)
        else $error("secondary reset pulsed in high gain");
    quarter_rate_a: assert property (QUARTER_RES_RESET_SAMPLE |-> qgap_r >= 4 * HALF_PIX_CYC - 1)
        else $error("quarter strobe too fast");
    gain_pairs_a: assert property ({LOW_GAIN_RESET_SAMPLE, LOW_GAIN_DATA_SAMPLE} == {HIGH_GAIN_RESET_SAMPLE, HIGH_GAIN_DATA_SAMPLE})
        else $error("gain strobe pairs differ");
endmodule // ccd_seq_checker

bind ccd_readout_clock_sequencer ccd_seq_checker #(.XFER_CYC(XFER_CYC), .HALF_PIX_CYC(HALF_PIX_CYC)) chk (.*);

// File: verif/ccd_sensor_model.sv
// behavioural model of the sensor charge path
`timescale 1ns/100ps
module ccd_sensor_model (
    input wire logic top_gate,
    input wire logic bottom_gate,
    input wire logic vert_clk,
    input wire logic dump_upper,
    input wire logic dump_lower,
    output int xfers,
    output int drained,
    output int moved
);
    // ----------------------------------------
    // charge path
    // ----------------------------------------
    wire pulse = top_gate & bottom_gate;
    logic bloom_guard_r = 1'h1;
    initial begin
        xfers = 0;
        drained = 0;
        moved = 0;
    end
    // charge starts moving; overflow suppression off while high
    always @(posedge pulse) bloom_guard_r = 1'h0;
    // move complete, integration closes on this edge
    always @(negedge pulse) begin
        bloom_guard_r = 1'h1;
        xfers++;
    end
    // a half-raised dump pair still counts as moved: no partial drain
    always @(posedge vert_clk) begin
        if (dump_upper && dump_lower) drained++;
        else moved++;
    end
endmodule // ccd_sensor_model

// File: verif/tb_ccd_readout_clock_sequencer.sv
// self-checking bench for the ccd clock sequencer
`timescale 1ns/100ps
module tb_ccd_readout_clock_sequencer;
    localparam int LINES = 8;
    localparam int PIX = ccd_seq_pkg::PIX_PER_LINE;
    logic CLK, RST_B, FRAME_START, QUARTER_SEL, SHUTTER_EN, p_prev, s_prev, sh_prev;
    logic [1:0] GAIN_SEL;
    logic [3:0] OUT_EN, HORIZ_CLK1, PRIMARY_RESET, h_prev;
    logic [15:0] DUMP_LINES, SHUTTER_LINE;
    logic TOP_TRANSFER_GATE, BOTTOM_TRANSFER_GATE, VERT_CLK, DUMP_GATE_UPPER_PAIR, DUMP_GATE_LOWER_PAIR, SHUTTER;
    logic SECONDARY_RESET_UPPER, SECONDARY_RESET_LOWER, FULL_RES_RESET_SAMPLE, FULL_RES_DATA_SAMPLE, BUSY;
    logic QUARTER_RES_RESET_SAMPLE, QUARTER_RES_DATA_SAMPLE, LOW_GAIN_RESET_SAMPLE, LOW_GAIN_DATA_SAMPLE;
    logic HIGH_GAIN_RESET_SAMPLE, HIGH_GAIN_DATA_SAMPLE;
    logic [31:0] seed;
    int failures, total_checks, xfers, drained, moved, pf, sf, fr, qr, lg, sh;
    int hf[4];
    ccd_readout_clock_sequencer #(.LINES(LINES)) DUT (.*);
    ccd_sensor_model SENSOR (
        .top_gate(TOP_TRANSFER_GATE), .bottom_gate(BOTTOM_TRANSFER_GATE), .vert_clk(VERT_CLK),
        .dump_upper(DUMP_GATE_UPPER_PAIR), .dump_lower(DUMP_GATE_LOWER_PAIR),
        .xfers(xfers), .drained(drained), .moved(moved)
    );
    // ----------------------------------------
    // clock, observers, compare tasks
    // ----------------------------------------
    initial begin
        CLK = 1'h0;
        forever #2.5 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        for (int i = 0; i < 4; i++) begin
            if (h_prev[i] && !HORIZ_CLK1[i]) hf[i]++;
        end
        if (p_prev && !PRIMARY_RESET[0]) pf++;
        if (s_prev && !SECONDARY_RESET_UPPER) sf++;
        if (!sh_prev && SHUTTER) sh++;
        fr += FULL_RES_RESET_SAMPLE + FULL_RES_DATA_SAMPLE;
        qr += QUARTER_RES_RESET_SAMPLE + QUARTER_RES_DATA_SAMPLE;
        lg += LOW_GAIN_RESET_SAMPLE + LOW_GAIN_DATA_SAMPLE;
        h_prev = HORIZ_CLK1;
        p_prev = PRIMARY_RESET[0];
        s_prev = SECONDARY_RESET_UPPER;
        sh_prev = SHUTTER;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check_num(input string what, input int exp, input int got);
        total_checks++;
        if (exp != got) begin
            failures++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (exp !== got) begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one frame; config is scrambled mid-frame and must not take effect
    task automatic run_frame(input int k);
        logic [1:0] g;
        logic [3:0] oe;
        logic q, qq;
        int nd, nn, per, x0, d0, m0;
        g = 2'(k % 3);
        q = ((k / 3) % 2) == 1;
        seed = lfsr(seed);
        oe = seed[3:0] | 4'h1;
        @(posedge CLK);
        #1;
        GAIN_SEL = g;
        QUARTER_SEL = q;
        OUT_EN = oe;
        SHUTTER_EN = k[0];
        SHUTTER_LINE = {13'h0000, seed[6:4]};
        DUMP_LINES = (k == 0) ? 16'h0000 : (k == 5) ? 16'hFFFF : seed[31:16];
        x0 = xfers;
        d0 = drained;
        m0 = moved;
        hf = '{0, 0, 0, 0};
        {pf, sf, fr, qr, lg, sh} = {6{32'h0}};
        FRAME_START = 1'h1;
        @(posedge CLK);
        #1 FRAME_START = 1'h0;
        check_bit("busy at start", 1'h1, BUSY);
        repeat (20) @(posedge CLK);
        #1 {FRAME_START, GAIN_SEL, QUARTER_SEL, OUT_EN} = {1'h1, ~g, ~q, ~oe};
        @(posedge CLK);
        #1 FRAME_START = 1'h0;
        for (int n = 0; n < 5000 && BUSY === 1'h1; n++) @(posedge CLK);
        #1;
        check_bit("busy at end", 1'h0, BUSY);
        nd = $countones(DUMP_LINES[LINES-1:0]);
        nn = LINES - nd;
        qq = q || g == ccd_seq_pkg::GAIN_EXTENDED_RANGE_MODE;
        per = qq ? PIX / 2 : PIX;
        check_num("transfers", 1, xfers - x0);
        check_num("drain balance", (moved - m0) * nd, (drained - d0) * nn);
        check_num("drained seen", nd > 0, (drained - d0) > 0);
        for (int i = 0; i < 4; i++) check_num("horiz falls", oe[i] ? PIX * nn : 0, hf[i]);
        check_num("full strobes", qq ? 0 : 2 * PIX * nn, fr);
        check_num("quarter strobes", (qq && g != ccd_seq_pkg::GAIN_EXTENDED_RANGE_MODE) ? PIX * nn : 0, qr);
        check_num("low gain strobes", g == ccd_seq_pkg::GAIN_EXTENDED_RANGE_MODE ? PIX * nn : 0, lg);
        // a dumped line has no readout, so no shutter follows it
        check_num("shutter pulses", k[0] && !DUMP_LINES[SHUTTER_LINE[3:0]], sh);
        if (g != ccd_seq_pkg::GAIN_EXTENDED_RANGE_MODE) begin
            check_num("primary falls", g == ccd_seq_pkg::GAIN_HIGH ? per * nn : 0, pf);
            check_num("secondary falls", g == ccd_seq_pkg::GAIN_LOW ? per * nn : 0, sf);
        end
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        {RST_B, FRAME_START, QUARTER_SEL, SHUTTER_EN, GAIN_SEL, OUT_EN} = '0;
        {DUMP_LINES, SHUTTER_LINE} = '0;
        {failures, total_checks} = '0;
        seed = 32'hA93E0D6E;
        repeat (8) @(posedge CLK);
        #1 RST_B = 1'h1;
        for (int k = 0; k < 6; k++) run_frame(k);
        // reset while the transfer pulse is up, then recover
        @(posedge CLK);
        #1 FRAME_START = 1'h1;
        @(posedge CLK);
        #1 FRAME_START = 1'h0;
        repeat (20) @(posedge CLK);
        #1 RST_B = 1'h0;
        #1;
        check_bit("busy in reset", 1'h0, BUSY);
        check_bit("gate in reset", 1'h0, TOP_TRANSFER_GATE);
        check_bit("horiz in reset", 1'h1, &HORIZ_CLK1);
        repeat (2) @(posedge CLK);
        #1 RST_B = 1'h1;
        run_frame(7);
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge CLK);
        failures++;
        end_of_test();
    end
endmodule // tb_ccd_readout_clock_sequencer
